/* rtl/voice_cmd_port.sv */
// serial command port with operation sequencer and axi4-lite status/test registers
// assumes the host drives sclk, mosi and select asynchronously; clock_i oversamples them
//
// Operation
// - array is 600 rows of 1600 cells, walked row by row
// - device is slave only; host drives serial clock
// - select falling edge starts a new frame
// - sample mosi on sclk rise, change miso on fall, lsb first
// - frame is 11 address bits then 5 control bits
// - end-of-message or end-of-memory sets interrupt; next frame clears it
// - status shifts out while command shifts in
// - run bit set starts, run bit clear stops operation
// - command acts only after select rises
// - 0 0 1 0 0 wakes; ready only after wake delay
// - 0 0 1 1 1 loads row, starts playback
// - 0 1 1 1 1 plays from current row until marker or end
// - 0 0 1 0 1 loads row, starts recording
// - 0 1 1 0 1 records from current row until end or stop
// - 1 0 1 1 1 loads row, starts cueing
// - 1 1 1 1 1 cues from current row to next marker or overflow
// - 0 1 1 x 0 stops, stays powered
// - x 1 0 x 0 stops and powers down
// - interrupt read returns overflow and end flags on miso
// - bits: cue, ignore address, power, play/record, run
// - cueing honoured only when playback begins
// - bit3 play/record, bit2 power, bit4 start/stop
// - ignore bit clear uses supplied row, set keeps current row
// - interrupt open-drain, active low, held until cleared
`timescale 1ns/100ps
`default_nettype none
module voice_cmd_port #(
	parameter int WAKE_CYC = voice_cmd_pkg::WAKE_DELAY_CYC,
	parameter int ROW_CYC = voice_cmd_pkg::ROW_TIME_CYC
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic sclk_i,
	input wire logic mosi_i,
	input wire logic sel_b_i,
	output logic miso_o,
	output logic miso_oe_o,
	output logic irq_b_o,
	output logic irq_oe_o,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int RB = voice_cmd_pkg::ROW_BITS;
	logic rst_s1_r, rst_n;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	logic [1:0] sclk_s_r, mosi_s_r, sel_s_r;
	logic sclk_d_r, sel_d_r;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sclk_s_r <= 2'h0;
			mosi_s_r <= 2'h0;
			sel_s_r <= 2'h3;
			sclk_d_r <= 1'b0;
			sel_d_r <= 1'b1;
		end else begin
			sclk_s_r <= {sclk_s_r[0], sclk_i};
			mosi_s_r <= {mosi_s_r[0], mosi_i};
			sel_s_r <= {sel_s_r[0], sel_b_i};
			sclk_d_r <= sclk_s_r[1];
			sel_d_r <= sel_s_r[1];
		end
	end
	wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
	wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
	wire sel_low = ~sel_s_r[1];
	wire frame_start = ~sel_s_r[1] & sel_d_r;
	wire frame_end = sel_s_r[1] & ~sel_d_r;

	// frame shifter
	logic [15:0] shift_r;
	logic [4:0] bit_cnt_r;
	logic [1:0] tx_r;
	logic miso_r;
	logic msg_end_flag, mem_end_flag;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			shift_r <= 16'h0000;
			bit_cnt_r <= 5'h00;
		end else if (frame_start) begin
			bit_cnt_r <= 5'h00;
		end else if (sel_low && sclk_rise) begin
			shift_r <= {mosi_s_r[1], shift_r[15:1]};
			if (bit_cnt_r != 5'h10)
				bit_cnt_r <= bit_cnt_r + 5'h01;
		end
	end
	// status latched at frame start, shifted out on sclk fall
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_r <= 2'h0;
			miso_r <= 1'b0;
		end else if (frame_start) begin
			tx_r <= {1'b0, msg_end_flag};
			miso_r <= mem_end_flag;
		end else if (sel_low && sclk_fall) begin
			miso_r <= tx_r[0];
			tx_r <= {1'b0, tx_r[1]};
		end
	end
	assign miso_o = miso_r;
	assign miso_oe_o = sel_low;

	// field decode; address bit 10 and x bits unused
	wire [RB-1:0] f_row = shift_r[RB-1:0];
	wire [4:0] ctl = shift_r[15:11];
	wire c_cue = ctl[voice_cmd_pkg::CUE_POS];
	wire c_ign = ctl[voice_cmd_pkg::IGN_POS];
	wire c_pwr = ctl[voice_cmd_pkg::PWR_POS];
	wire c_play = ctl[voice_cmd_pkg::PLAY_POS];
	wire c_run = ctl[voice_cmd_pkg::RUN_POS];
	wire full = bit_cnt_r == 5'h10;
	// commands act only at select rise after a full frame
	wire go = frame_end & full;
	wire cmd_wake = go & ~c_run & ~c_cue & ~c_ign & c_pwr & ~c_play;
	// plain stop, also serves as status read
	wire cmd_stop = go & ~c_run & ~c_cue & c_ign & c_pwr;
	wire cmd_halt_sleep = go & ~c_run & c_ign & ~c_pwr;
	wire cmd_start = go & c_run & c_pwr;

	logic powered_r, ready_r;
	logic [31:0] wake_cnt_r;
	voice_cmd_pkg::op_t op_r, op_nxt;
	logic [RB-1:0] row_r;
	logic [15:0] row_tmr_r;
	logic [RB-1:0] mark_row_r;
	logic mark_en_r;
	logic [15:0] ev_cnt_r;
	logic [1:0] last_ev_r;

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			powered_r <= 1'b0;
			ready_r <= 1'b0;
			wake_cnt_r <= 32'h0;
		end else if (cmd_halt_sleep) begin
			powered_r <= 1'b0;
			ready_r <= 1'b0;
		end else if (cmd_wake && !powered_r) begin
			powered_r <= 1'b1;
			wake_cnt_r <= 32'(WAKE_CYC);
		end else if (powered_r && !ready_r) begin
			if (wake_cnt_r <= 32'h1)
				ready_r <= 1'b1;
			else
				wake_cnt_r <= wake_cnt_r - 32'h1;
		end
	end

	// model steps one row per ROW_CYC cycles, cueing one row per cycle, ROW_CYC times faster
	wire row_step = (op_r != voice_cmd_pkg::OP_IDLE) &&
		(row_tmr_r == 16'(((op_r == voice_cmd_pkg::OP_CUE) ? 1 : ROW_CYC) - 1));
	wire at_last = row_r == RB'(voice_cmd_pkg::ROW_COUNT - 1);
	// marker model: a marker written by software on mark_row_r
	wire at_mark = mark_en_r && (row_r == mark_row_r);
	wire hit_ovf = row_step && at_last;
	wire hit_eom = row_step && !at_last && at_mark &&
		((op_r == voice_cmd_pkg::OP_PLAY) || (op_r == voice_cmd_pkg::OP_CUE));
	wire [RB-1:0] start_row = c_ign ? row_r : f_row;

	always_comb begin
		op_nxt = op_r;
		if (cmd_stop || cmd_halt_sleep) begin
			op_nxt = voice_cmd_pkg::OP_IDLE;
		end else if (cmd_start && ready_r) begin
			case ({c_play, c_cue})
				2'b00: op_nxt = voice_cmd_pkg::OP_REC;
				2'b10: op_nxt = voice_cmd_pkg::OP_PLAY;
				// cue only as a playback begins
				2'b11: op_nxt = (op_r == voice_cmd_pkg::OP_PLAY) ? op_r : voice_cmd_pkg::OP_CUE;
				default: op_nxt = op_r;
			endcase
		end else if (go && !c_run) begin
			op_nxt = voice_cmd_pkg::OP_IDLE;
		end else if (hit_ovf || hit_eom) begin
			op_nxt = voice_cmd_pkg::OP_IDLE;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			op_r <= voice_cmd_pkg::OP_IDLE;
			row_r <= '0;
			row_tmr_r <= 16'h0;
		end else begin
			op_r <= op_nxt;
			if (cmd_start && ready_r && op_nxt != op_r) begin
				// supplied row unless ignore bit set
				row_r <= start_row;
				row_tmr_r <= 16'h0;
			end else if (row_step) begin
				row_tmr_r <= 16'h0;
				if (!at_last)
					row_r <= row_r + RB'(1);
			end else if (op_r != voice_cmd_pkg::OP_IDLE) begin
				row_tmr_r <= row_tmr_r + 16'h1;
			end
		end
	end

	// flags set on termination, cleared at next frame start; set wins
	logic irq_r;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_r <= 1'b0;
			msg_end_flag <= 1'b0;
			mem_end_flag <= 1'b0;
		end else if (hit_ovf || hit_eom) begin
			irq_r <= 1'b1;
			mem_end_flag <= hit_ovf;
			msg_end_flag <= hit_eom;
		end else if (frame_start) begin
			irq_r <= 1'b0;
			mem_end_flag <= 1'b0;
			msg_end_flag <= 1'b0;
		end
	end
	assign irq_b_o = 1'b0;
	assign irq_oe_o = irq_r;

	// axi4-lite slave: status, current row, marker row, event count
	logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	// strobes are kept with the data; the master may change them once w is taken
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	assign s_axi_awready = ~aw_got_r & ~bvalid_r;
	assign s_axi_wready = ~w_got_r & ~bvalid_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	wire wr_go = aw_got_r & w_got_r & ~bvalid_r;
	wire wr_mark = wr_go && awaddr_r == voice_cmd_pkg::MARK_OFS;
	wire [7:0] ra = s_axi_araddr[7:0];
	wire ra_ok = s_axi_araddr[31:8] == 24'h0 &&
		(ra == voice_cmd_pkg::STATUS_OFS || ra == voice_cmd_pkg::ROW_OFS ||
		ra == voice_cmd_pkg::MARK_OFS || ra == voice_cmd_pkg::EVENT_OFS);
	wire [31:0] status_word = {22'h0, last_ev_r, mem_end_flag, msg_end_flag, irq_r,
		ready_r, powered_r, 1'b0, op_r};
	wire [31:0] rd_mux = (ra == voice_cmd_pkg::STATUS_OFS) ? status_word :
		(ra == voice_cmd_pkg::ROW_OFS) ? {22'h0, row_r} :
		(ra == voice_cmd_pkg::MARK_OFS) ? {mark_en_r, 21'h0, mark_row_r} :
		(ra == voice_cmd_pkg::EVENT_OFS) ? {16'h0, ev_cnt_r} : 32'h0;

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
			awaddr_r <= 8'h0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bresp_r <= voice_cmd_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= (s_axi_awaddr[31:8] == 24'h0) ? s_axi_awaddr[7:0] : 8'hff;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (awaddr_r == voice_cmd_pkg::MARK_OFS || awaddr_r == voice_cmd_pkg::EVENT_OFS)
					? voice_cmd_pkg::RESP_OKAY : voice_cmd_pkg::RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= voice_cmd_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= ra_ok ? voice_cmd_pkg::RESP_OKAY : voice_cmd_pkg::RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// marker register steers the playback model; event count writes clear it
	wire wr_ev = wr_go && awaddr_r == voice_cmd_pkg::EVENT_OFS;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			mark_row_r <= '0;
			mark_en_r <= 1'b0;
			ev_cnt_r <= 16'h0;
			last_ev_r <= 2'h0;
		end else begin
			if (wr_mark && wdata_r != 32'h0 && wstrb_r != 4'h0) begin
				mark_row_r <= wdata_r[RB-1:0];
				mark_en_r <= wdata_r[31];
			end else if (wr_mark) begin
				mark_en_r <= 1'b0;
			end
			if (hit_ovf || hit_eom) begin
				ev_cnt_r <= ev_cnt_r + 16'h1;
				last_ev_r <= {hit_ovf, hit_eom};
			end else if (wr_ev) begin
				ev_cnt_r <= 16'h0;
			end
		end
	end

	// interrupt rises with the terminating event
	a_irq_on_end: assert property (@(posedge clock_i) disable iff (!rst_n)
		(hit_ovf || hit_eom) |=> irq_oe_o) else $error("interrupt missing after end");
	a_irq_clear: assert property (@(posedge clock_i) disable iff (!rst_n)
		(frame_start && !hit_ovf && !hit_eom) |=> !irq_oe_o) else $error("interrupt not cleared");
	a_irq_hold: assert property (@(posedge clock_i) disable iff (!rst_n)
		(irq_oe_o && !frame_start) |=> irq_oe_o) else $error("interrupt dropped early");
	a_no_mid_frame: assert property (@(posedge clock_i) disable iff (!rst_n)
		(sel_low && op_r == voice_cmd_pkg::OP_IDLE && !hit_ovf) |=> op_r == voice_cmd_pkg::OP_IDLE)
		else $error("operation began inside frame");
	a_wake_gate: assert property (@(posedge clock_i) disable iff (!rst_n)
		!ready_r |=> (op_r == voice_cmd_pkg::OP_IDLE || $past(op_r) != voice_cmd_pkg::OP_IDLE))
		else $error("operation before wake delay");
	a_stop_idle: assert property (@(posedge clock_i) disable iff (!rst_n)
		(cmd_stop || cmd_halt_sleep) |=> op_r == voice_cmd_pkg::OP_IDLE) else $error("stop ignored");
	a_sleep_off: assert property (@(posedge clock_i) disable iff (!rst_n)
		cmd_halt_sleep |=> !powered_r && !ready_r) else $error("power-down ignored");
	a_miso_idle: assert property (@(posedge clock_i) disable iff (!rst_n)
		(!sclk_fall && !frame_start) |=> $stable(miso_r)) else $error("miso changed off fall edge");
	a_row_load: assert property (@(posedge clock_i) disable iff (!rst_n)
		(cmd_start && ready_r && !c_ign && op_nxt != op_r) |=> row_r == $past(f_row))
		else $error("supplied row not loaded");
	a_ovf_stop: assert property (@(posedge clock_i) disable iff (!rst_n)
		(hit_ovf && !go) |=> op_r == voice_cmd_pkg::OP_IDLE && mem_end_flag) else $error("no stop at end");
endmodule
`default_nettype wire

/* rtl/voice_cmd_pkg.sv */
// constants for the voice recorder serial command port
// assumes a 200 MHz system clock; link pins are asynchronous to it
package voice_cmd_pkg;
	localparam int ROW_COUNT = 600;
	localparam int CELLS_PER_ROW = 1600;
	localparam int ADDR_BITS = 11;
	localparam int ROW_BITS = 10;
	localparam int CTL_BITS = 5;
	localparam int FRAME_BITS = 16;
	localparam int CLK_MHZ = 200;
	// wake delay in microseconds, and its cycle count
	localparam int WAKE_DELAY_US = 25000;
	localparam int WAKE_DELAY_CYC = WAKE_DELAY_US * CLK_MHZ;
	// cycles the model spends in one row; parameterisable in the top
	localparam int ROW_TIME_CYC = 64;
	// control field positions
	localparam int CUE_POS = 0;
	localparam int IGN_POS = 1;
	localparam int PWR_POS = 2;
	localparam int PLAY_POS = 3;
	localparam int RUN_POS = 4;
	// axi register offsets
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] ROW_OFS = 8'h04;
	localparam logic [7:0] MARK_OFS = 8'h08;
	localparam logic [7:0] EVENT_OFS = 8'h0c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_PLAY = 2'b01,
		OP_REC = 2'b10,
		OP_CUE = 2'b11
	} op_t;
endpackage

/* tb/host_model.sv */
// host side of the serial command port: frames a 16-bit word lsb first and collects two status bits
// assumes the port oversamples the link pins; serial clock stands low between frames
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input wire logic miso_i,
	input wire logic miso_oe_i,
	output logic sclk_o,
	output logic mosi_o,
	output logic sel_b_o,
	output logic [1:0] stat_o,
	output logic done_o
);
	logic last;
	initial begin
		sclk_o = 1'b0;
		mosi_o = 1'b0;
		sel_b_o = 1'b1;
		stat_o = 2'h0;
		done_o = 1'b0;
		last = 1'b0;
	end
	task automatic frame(input logic [15:0] w);
		logic [15:0] got;
		sel_b_o <= 1'b0;
		#60;
		for (int i = 0; i < 16; i++) begin
			mosi_o <= w[i];
			#24;
			got[i] = miso_oe_i ? miso_i : ~last;
			last = got[i];
			sclk_o <= 1'b1;
			#24;
			sclk_o <= 1'b0;
		end
		#60;
		sel_b_o <= 1'b1;
		// released data line must not keep its last level
		mosi_o <= ~w[15];
		stat_o <= got[1:0];
		done_o <= ~done_o;
		#100;
	endtask
endmodule
`default_nettype wire

/* tb/test_voice_recorder_serial_command_port.sv */
// self-checking bench for the voice command port
// assumes the host model owns the link pins and the tasks below act as axi4-lite master
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_voice_recorder_serial_command_port;
	logic clock_i, rst_b_i, sclk, mosi, sel_b, miso, miso_oe, irq_b, irq_oe, irq_line, done;
	logic [1:0] stat, bresp, rresp;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [33:0] exp_q[$];
	logic [33:0] msk_q[$];
	logic [9:0] r;
	int err_count = 0;
	int tests_run = 0;
	int seed = 3077;
	localparam logic [31:0] ST = {24'h0, voice_cmd_pkg::STATUS_OFS};
	localparam logic [31:0] RW = {24'h0, voice_cmd_pkg::ROW_OFS};
	localparam logic [31:0] MK = {24'h0, voice_cmd_pkg::MARK_OFS};
	localparam logic [31:0] EV = {24'h0, voice_cmd_pkg::EVENT_OFS};
	localparam logic [1:0] OK = voice_cmd_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = voice_cmd_pkg::RESP_SLVERR;
	// open-drain line with pull-up
	assign irq_line = irq_oe ? irq_b : 1'b1;
	voice_cmd_port #(.WAKE_CYC(20), .ROW_CYC(64)) voice_cmd_port_i (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.sclk_i(sclk), .mosi_i(mosi), .sel_b_i(sel_b), .miso_o(miso), .miso_oe_o(miso_oe),
		.irq_b_o(irq_b), .irq_oe_o(irq_oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	host_model host_model_i (.miso_i(miso), .miso_oe_i(miso_oe), .sclk_o(sclk), .mosi_o(mosi),
		.sel_b_o(sel_b), .stat_o(stat), .done_o(done));
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	task automatic check(input logic [33:0] v);
		logic [33:0] e;
		logic [33:0] m;
		e = exp_q.pop_front();
		m = msk_q.pop_front();
		`CHK(v & m, e)
	endtask
	always @(posedge clock_i) begin
		if (rvalid && rready)
			check({rresp, rdata});
		if (bvalid && bready)
			check({bresp, 32'h0});
	end
	always @(done) begin
		if ($time > 0)
			check({32'h0, stat});
	end
	task automatic rd(input logic [31:0] a, input logic [1:0] rs, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back({rs, e & m});
		msk_q.push_back({2'h3, m});
		@(posedge clock_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock_i); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clock_i); while (!rvalid);
		rready <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] rs);
		logic ad;
		logic wd;
		exp_q.push_back({rs, 32'h0});
		msk_q.push_back({2'h3, 32'h0});
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clock_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock_i);
			if (!ad && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end while (!(ad && wd));
		do @(posedge clock_i); while (!bvalid);
		bready <= 1'b0;
	endtask
	// e and m cover the two status bits returned in the frame
	task automatic cmd(input logic [4:0] c, input logic [10:0] a, input logic [1:0] e, input logic [1:0] m);
		exp_q.push_back({32'h0, e});
		msk_q.push_back({32'h0, m});
		host_model_i.frame({c, a});
		repeat (8) @(posedge clock_i);
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 2000 && irq_line !== 1'b0; i++)
			@(posedge clock_i);
	endtask
	task automatic report_and_stop();
		if (err_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#300000;
		err_count++;
		report_and_stop();
	end
	initial begin
		rst_b_i = 1'b0;
		{awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hf;
		repeat (16) @(posedge clock_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		rd(ST, OK, 32'h0, 32'h1b);
		rd(32'h10, ERR, 32'h0, 32'h0);
		wr(ST, 32'h1, ERR);
		cmd(5'b00100, 11'h7ff, 2'h0, 2'h0);
		repeat (40) @(posedge clock_i);
		rd(ST, OK, 32'h18, 32'h1b);
		r = 10'(100 + ($unsigned($random(seed)) % 400));
		cmd(5'b11100, {1'b1, r}, 2'h0, 2'h0);
		rd(ST, OK, 32'h19, 32'h1b);
		rd(RW, OK, {22'h0, r}, 32'h3ff);
		cmd(5'b01110, 11'h0, 2'h0, 2'h3);
		rd(ST, OK, 32'h18, 32'h1b);
		cmd(5'b11110, 11'h0, 2'h0, 2'h0);
		rd(ST, OK, 32'h19, 32'h1b);
		cmd(5'b00110, 11'h0, 2'h0, 2'h0);
		cmd(5'b10100, 11'h256, 2'h0, 2'h0);
		wait_irq();
		`CHK(irq_line, 1'b0)
		rd(ST, OK, 32'hb8, 32'hbb);
		cmd(5'b00110, 11'h0, 2'b01, 2'h3);
		`CHK(irq_line, 1'b1)
		wr(MK, 32'h8000000a, OK);
		rd(MK, OK, 32'h8000000a, 32'h800003ff);
		cmd(5'b11101, 11'h3, 2'h0, 2'h0);
		wait_irq();
		`CHK(irq_line, 1'b0)
		rd(ST, OK, 32'h60, 32'h63);
		cmd(5'b00110, 11'h0, 2'b10, 2'h3);
		cmd(5'b11111, 11'h0, 2'h0, 2'h0);
		wait_irq();
		`CHK(irq_line, 1'b0)
		cmd(5'b00110, 11'h0, 2'h0, 2'h0);
		rd(EV, OK, 32'h3, 32'hffffffff);
		wr(EV, 32'h0, OK);
		rd(EV, OK, 32'h0, 32'hffffffff);
		cmd(5'b10110, 11'h0, 2'h0, 2'h0);
		rd(ST, OK, 32'h1a, 32'h1b);
		// recording from the last row overflows during this frame
		cmd(5'b01011, 11'h0, 2'h0, 2'h0);
		rd(ST, OK, 32'h0, 32'h1b);
		`CHK(irq_line, 1'b0)
		// start while asleep is refused; the frame still reads the overflow
		cmd(5'b11100, 11'h5, 2'b01, 2'h3);
		`CHK(irq_line, 1'b1)
		rd(ST, OK, 32'h0, 32'h1b);
		report_and_stop();
	end
endmodule
`default_nettype wire
